/* File: fdc_regs_pkg.sv */
// Package of register map, field positions and carriers of the floppy block
package fdc_regs_pkg;
   // Bus geometry: byte address is four times the register index
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam int IDX_W = 4;
   localparam logic [IDX_W-1:0] IDX_DOC = 4'h2;
   localparam logic [IDX_W-1:0] IDX_MST = 4'h4;
   localparam logic [IDX_W-1:0] IDX_PORT = 4'h5;
   localparam logic [IDX_W-1:0] IDX_DIN = 4'h7;
   localparam logic [IDX_W-1:0] IDX_IST = 4'h8;
   localparam logic [IDX_W-1:0] IDX_IMSK = 4'h9;
   // Output control fields
   localparam int B_MOT2 = 5;
   localparam int B_MOT1 = 4;
   localparam int B_GATE = 3;
   localparam int B_SRST = 2;
   localparam int B_DSEL = 0;
   localparam logic [7:0] DOC_RST = 8'h00;
   localparam logic [7:0] DOC_WMASK = 8'h3d;
   // Main status fields
   localparam int S_RDY = 7;
   localparam int S_XDIR = 6;
   localparam int S_NDMA = 5;
   localparam int S_BUSY = 4;
   localparam int S_SEEK2 = 1;
   localparam int S_SEEK1 = 0;
   // Input state field
   localparam int B_CHG = 7;
   // Rate field and its codes
   localparam int RATE_W = 2;
   localparam logic [RATE_W-1:0] RATE_500K = 2'h0;
   localparam logic [RATE_W-1:0] RATE_300K = 2'h1;
   localparam logic [RATE_W-1:0] RATE_250K = 2'h2;
   localparam logic [RATE_W-1:0] RATE_1M = 2'h3;
   // Interrupt event bits
   localparam int EV_W = 3;
   localparam int EV_RES = 0;
   localparam int EV_DONE = 1;
   localparam int EV_CHG = 2;
   localparam logic [EV_W-1:0] EV_RST = 3'h0;
   // Status coming from the controller core
   typedef struct packed {
      logic port_ready_flag;
      logic transfer_direction;
      logic non_dma_flag;
      logic command_busy;
      logic second_drive_seeking;
      logic first_drive_seeking;
      logic irq_req;
      logic dma_req;
   } core_stat_s;
   // Rate selection handed to the clock divider
   typedef struct packed {
      logic [RATE_W-1:0] code;
      logic reduce_write;
   } rate_cfg_s;
endpackage

/* File: floppy_host_register_interface.sv */
// Host register set of the floppy controller on a classic Wishbone slave
// Behaviour
// - Motor outputs follow control bits 5 and 4
// - Bit 3 gates disk interrupt and DMA request
// - Bit 2 low resets controller, keeps registers
// - Bit 0 selects drive A or drive B
// - Interface reset clears the output control register
// - Ready bit set only when port can transfer
// - Bit 6 gives direction while ready is set
// - Bit 5 reports non-DMA mode
// - Bit 4 busy from command until result ends
// - Bits 1 and 0 show drive seeking
// - Data port is a stack, one byte shown
// - Input bit 7 is inverse of change pin
// - Input bits 6 to 0 are undefined
// - Rate field decodes rate, clock, reduce-write
// - Registers at offsets 02h, 04h, 05h, 07h
//
// Added by the designer: the Wishbone register port.
module floppy_host_register_interface #(
   parameter int STACK_DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [fdc_regs_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [fdc_regs_pkg::DATA_W-1:0] wb_dat_i,
   output logic [fdc_regs_pkg::DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire fdc_regs_pkg::core_stat_s core_stat,
   input wire logic res_push,
   input wire logic [7:0] res_byte,
   output logic res_full,
   output logic cmd_strobe,
   output logic [7:0] cmd_byte,
   input wire logic media_changed_pin_n,
   output logic motor_first_on,
   output logic motor_second_on,
   output logic drive_choose,
   output logic ctrl_reset_n,
   output logic disk_irq,
   output logic dma_req,
   output fdc_regs_pkg::rate_cfg_s rate_cfg,
   output logic int_o
);
   import fdc_regs_pkg::*;

   // Stack pointer width; depth must be a power of two to wrap cleanly
   localparam int PW = $clog2(STACK_DEPTH);
   localparam logic [PW:0] DEPTH_C = (PW+1)'(STACK_DEPTH);

   // Register index decode, shared by every access strobe
   function automatic logic is_idx(input logic [IDX_W-1:0] a,
                                   input logic [IDX_W-1:0] i);
      return a == i;
   endfunction

   // Reduce-write is off only for the 500K setting
   function automatic logic reduce_of(input logic [RATE_W-1:0] c);
      return c != RATE_500K;
   endfunction

   // Bus handshake state
   logic ack_r, ack_nxt;
   logic [DATA_W-1:0] dat_r, dat_nxt;
   // Access qualifiers
   logic [IDX_W-1:0] idx;
   logic acc, wr, rd;
   logic wr_doc, wr_port, wr_rate, wr_msk;
   logic rd_port, rd_ist, rd_din;

   // Output control register and its next value
   logic [7:0] doc_r, doc_nxt;
   // Rate register
   rate_cfg_s rate_r, rate_nxt;
   // Command byte handed to the core
   logic cmd_stb_r, cmd_stb_nxt;
   logic [7:0] cmd_r, cmd_nxt;
   // Gated requests toward the host
   logic irq_r, irq_nxt, dreq_r, dreq_nxt;

   // Result stack
   logic [7:0] mem [STACK_DEPTH];
   logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [PW:0] cnt_r, cnt_nxt;
   logic full_r, full_nxt;
   logic push, pop;

   // Status assembly
   logic rdy;
   logic [7:0] mst_v;

   // Event flags and interrupt
   logic [EV_W-1:0] ist_r, ist_nxt, msk_r, msk_nxt, ev;
   logic int_r, int_nxt;
   logic busy_d_r, chg_d_r;

   assign idx = wb_adr_i[ADDR_W-1:2];
   // A new request is one not yet acknowledged
   assign acc = wb_cyc_i & wb_stb_i & ~ack_r;
   // Only lane 0 carries data; other lanes are ignored
   assign wr = acc & wb_we_i & wb_sel_i[0];
   assign rd = acc & ~wb_we_i;
   assign wr_doc = wr & is_idx(idx, IDX_DOC);
   assign wr_port = wr & is_idx(idx, IDX_PORT);
   assign wr_rate = wr & is_idx(idx, IDX_DIN);
   assign wr_msk = wr & is_idx(idx, IDX_IMSK);
   assign rd_port = rd & is_idx(idx, IDX_PORT);
   assign rd_ist = rd & is_idx(idx, IDX_IST);
   assign rd_din = rd & is_idx(idx, IDX_DIN);

   // Main status image
   always_comb begin
      // Ready means a byte can move: data waiting, or a free slot
      if (core_stat.transfer_direction) begin
         rdy = core_stat.port_ready_flag & (cnt_r != '0);
      end else begin
         rdy = core_stat.port_ready_flag & ~cmd_stb_r;
      end
      mst_v = '0;
      mst_v[S_RDY] = rdy;
      // Direction is only meaningful while ready
      mst_v[S_XDIR] = rdy & core_stat.transfer_direction;
      mst_v[S_NDMA] = core_stat.non_dma_flag;
      mst_v[S_BUSY] = core_stat.command_busy;
      mst_v[S_SEEK2] = core_stat.second_drive_seeking;
      mst_v[S_SEEK1] = core_stat.first_drive_seeking;
   end

   // Bus answer: ack one cycle after the request, read data with it
   always_comb begin
      ack_nxt = acc;
      dat_nxt = dat_r;
      if (rd) begin
         dat_nxt = '0;
         unique case (idx)
            IDX_DOC: dat_nxt[7:0] = doc_r;
            IDX_MST: dat_nxt[7:0] = mst_v;
            // Empty stack reads as zero
            IDX_PORT: dat_nxt[7:0] = (cnt_r != '0) ? mem[rp_r] : '0;
            // Low bits float on the pin bus; here they read zero
            IDX_DIN: dat_nxt[B_CHG] = ~media_changed_pin_n;
            IDX_IST: dat_nxt[EV_W-1:0] = ist_r;
            IDX_IMSK: dat_nxt[EV_W-1:0] = msk_r;
            // Unmapped indices are acknowledged with zero
            default: dat_nxt = '0;
         endcase
      end
   end

   // Bus registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
         dat_r <= '0;
      end else begin
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
      end
   end

   // Control registers: output control, rate, command byte, gates
   always_comb begin
      doc_nxt = doc_r;
      rate_nxt = rate_r;
      cmd_nxt = cmd_r;
      // Strobe lasts one cycle per host write
      cmd_stb_nxt = 1'b0;
      // Reserved bits stay zero
      if (wr_doc) begin
         doc_nxt = wb_dat_i[7:0] & DOC_WMASK;
      end
      // Rate survives the soft reset bit
      if (wr_rate) begin
         rate_nxt.code = wb_dat_i[RATE_W-1:0];
         rate_nxt.reduce_write = reduce_of(wb_dat_i[RATE_W-1:0]);
      end
      // Bytes written under soft reset are dropped
      if (wr_port && doc_r[B_SRST]) begin
         cmd_nxt = wb_dat_i[7:0];
         cmd_stb_nxt = 1'b1;
      end
      // Gate both host requests with the enable bit
      irq_nxt = doc_r[B_GATE] & core_stat.irq_req;
      dreq_nxt = doc_r[B_GATE] & core_stat.dma_req;
   end

   // Control register state; interface reset clears everything
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         doc_r <= DOC_RST;
         rate_r <= '{code: RATE_500K, reduce_write: 1'b0};
         cmd_r <= '0;
         cmd_stb_r <= 1'b0;
         irq_r <= 1'b0;
         dreq_r <= 1'b0;
      end else begin
         doc_r <= doc_nxt;
         rate_r <= rate_nxt;
         cmd_r <= cmd_nxt;
         cmd_stb_r <= cmd_stb_nxt;
         irq_r <= irq_nxt;
         dreq_r <= dreq_nxt;
      end
   end

   // Stack control: the core pushes result bytes, host reads pop them
   always_comb begin
      push = res_push & ~full_r & doc_r[B_SRST];
      pop = rd_port & (cnt_r != '0);
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      cnt_nxt = cnt_r;
      if (push) begin
         wp_nxt = wp_r + 1'b1;
      end
      if (pop) begin
         rp_nxt = rp_r + 1'b1;
      end
      // Count moves only when one side acts alone
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
      // Soft reset empties the stack but no register
      if (!doc_r[B_SRST]) begin
         wp_nxt = '0;
         rp_nxt = '0;
         cnt_nxt = '0;
      end
      full_nxt = cnt_nxt == DEPTH_C;
   end

   // Stack pointers and count
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         full_r <= 1'b0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
         full_r <= full_nxt;
      end
   end

   // Stack storage; no reset needed since the count guards reads
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wp_r] <= res_byte;
      end
   end

   // Events: result byte, end of busy, new media change
   always_comb begin
      ev = '0;
      ev[EV_RES] = push;
      ev[EV_DONE] = busy_d_r & ~core_stat.command_busy;
      ev[EV_CHG] = ~media_changed_pin_n & ~chg_d_r;
      // Read clears, but a fresh event in that cycle wins
      ist_nxt = (rd_ist ? EV_RST : ist_r) | ev;
      msk_nxt = wr_msk ? wb_dat_i[EV_W-1:0] : msk_r;
      int_nxt = |(ist_nxt & msk_nxt);
   end

   // Event and interrupt registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ist_r <= EV_RST;
         msk_r <= EV_RST;
         int_r <= 1'b0;
         busy_d_r <= 1'b0;
         chg_d_r <= 1'b0;
      end else begin
         ist_r <= ist_nxt;
         msk_r <= msk_nxt;
         int_r <= int_nxt;
         busy_d_r <= core_stat.command_busy;
         chg_d_r <= ~media_changed_pin_n;
      end
   end

   // Outputs, all straight from flip-flops
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign motor_second_on = doc_r[B_MOT2];
   assign motor_first_on = doc_r[B_MOT1];
   assign drive_choose = doc_r[B_DSEL];
   assign ctrl_reset_n = doc_r[B_SRST];
   assign disk_irq = irq_r;
   assign dma_req = dreq_r;
   assign rate_cfg = rate_r;
   assign res_full = full_r;
   assign cmd_strobe = cmd_stb_r;
   assign cmd_byte = cmd_r;
   assign int_o = int_r;

   // Checks beside the logic
   a_motor_write: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      wr_doc |=> motor_first_on == $past(wb_dat_i[B_MOT1])
         && motor_second_on == $past(wb_dat_i[B_MOT2]))
      else $error("motor enable does not follow write");

   a_gate_requests: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (disk_irq || dma_req) |-> $past(doc_r[B_GATE]))
      else $error("request passed while gate was off");

   a_soft_reset_keep: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (!doc_r[B_SRST] && !wr_rate && !wr_doc)
         |=> cnt_r == '0 && $stable(rate_cfg) && $stable(doc_r))
      else $error("soft reset touched a register");

   a_drive_select: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      wr_doc |=> drive_choose == $past(wb_dat_i[B_DSEL]))
      else $error("drive select does not follow write");

   a_reset_clear: assert property (
      @(posedge clk_sys)
      !rst_n |=> doc_r == DOC_RST && !motor_first_on)
      else $error("output control not cleared by reset");

   a_ready_data: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      mst_v[S_XDIR] |-> mst_v[S_RDY] && cnt_r != '0)
      else $error("read ready without data");

   a_busy_event: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      $fell(core_stat.command_busy) |=> ist_r[EV_DONE])
      else $error("end of busy not flagged");

   a_stack_pop: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (pop && !push && doc_r[B_SRST]) |=> cnt_r == $past(cnt_r) - 1'b1)
      else $error("port read did not pop one byte");

   a_change_read: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      rd_din |=> wb_dat_o[B_CHG] == !$past(media_changed_pin_n))
      else $error("change bit not inverse of pin");

   // Low input bits must read as a defined zero, not stale data
   a_input_low: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      rd_din |=> wb_dat_o[B_CHG-1:0] == '0)
      else $error("input state low bits not zero");

   a_nondma_flag: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (rd && is_idx(idx, IDX_MST))
         |=> wb_dat_o[S_NDMA] == $past(core_stat.non_dma_flag))
      else $error("non-DMA flag not reported");

   a_seek_bits: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (rd && is_idx(idx, IDX_MST))
         |=> wb_dat_o[S_SEEK2] == $past(core_stat.second_drive_seeking)
         && wb_dat_o[S_SEEK1] == $past(core_stat.first_drive_seeking))
      else $error("seek bits do not follow the core");

   // A full stack must drop a push rather than wrap over the oldest byte
   a_full_drop: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (res_push && res_full && !pop && doc_r[B_SRST]) |=> $stable(cnt_r))
      else $error("push accepted while stack full");

   a_rate_decode: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      wr_rate |=> rate_cfg.reduce_write
         == ($past(wb_dat_i[RATE_W-1:0]) != RATE_500K))
      else $error("reduce write decode wrong");

   a_ack_pulse: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      acc |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle after request");
endmodule

/* File: core_model.sv */
// Controller core stand-in: seeks, offers one result byte, then idles
module core_model #(
   parameter int SEEK_CYC = 20,
   parameter int HOLD_CYC = 40
) (
   input wire logic clk_sys,
   input wire logic ctrl_reset_n,
   input wire logic cmd_strobe,
   input wire logic [7:0] cmd_byte,
   input wire logic drive_choose,
   input wire logic ndma_i,
   output fdc_regs_pkg::core_stat_s core_stat,
   output logic res_push,
   output logic [7:0] res_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   import fdc_regs_pkg::*;
   int cnt = 0; // Cycles left in the phase
   logic busy = 1'b0; // Command running
   logic rdir = 1'b0; // Result byte offered to the host
   logic seek; // Seek portion of a command
   assign seek = busy & ~rdir;
   // Ready only when idle or offering a result, never in mid-seek
   assign core_stat = '{port_ready_flag: ctrl_reset_n & (~busy | rdir),
      transfer_direction: rdir, non_dma_flag: ndma_i, command_busy: busy,
      second_drive_seeking: seek & drive_choose,
      first_drive_seeking: seek & ~drive_choose,
      irq_req: rdir, dma_req: rdir};
   // Byte lines toggle outside a push, so a stale byte is never taken
   always @(posedge clk_sys) begin
      res_push <= 1'b0;
      res_byte <= ~res_byte;
      if (!ctrl_reset_n) begin
         busy <= 1'b0;
         rdir <= 1'b0;
         res_byte <= 8'h00;
      end else if (!busy && cmd_strobe) begin
         busy <= 1'b1;
         cnt <= SEEK_CYC;
      end else if (busy && cnt > 1) begin
         cnt <= cnt - 1;
      end else if (seek) begin
         rdir <= 1'b1;
         res_push <= 1'b1;
         res_byte <= cmd_byte + 8'h01;
         cnt <= HOLD_CYC;
      end else if (busy) begin
         busy <= 1'b0;
         rdir <= 1'b0;
      end
   end
endmodule

/* File: floppy_host_register_interface_tb.sv */
// Self-checking bench of the floppy host register block
module floppy_host_register_interface_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [5:0] adr = 6'h00;
   logic [31:0] wdat = 32'h0;
   logic [3:0] sel = 4'h0; // Byte enables, lane 0 only
   logic pin_n = 1'b1; // Change pin idles high
   logic ndma = 1'b0;
   logic [31:0] rdat;
   logic ack, res_push, res_full, cmd_strobe, int_o;
   logic [7:0] res_byte, cmd_byte;
   logic mot1, mot2, dsel, crst_n, disk_irq, dma_req;
   fdc_regs_pkg::core_stat_s core_stat;
   fdc_regs_pkg::rate_cfg_s rate_cfg;
   int error_cnt = 0;
   int tests_run = 0;
   int strobes = 0; // Port writes seen by the core
   floppy_host_register_interface dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .core_stat(core_stat), .res_push(res_push), .res_byte(res_byte),
      .res_full(res_full), .cmd_strobe(cmd_strobe), .cmd_byte(cmd_byte),
      .media_changed_pin_n(pin_n), .motor_first_on(mot1),
      .motor_second_on(mot2), .drive_choose(dsel), .ctrl_reset_n(crst_n),
      .disk_irq(disk_irq), .dma_req(dma_req), .rate_cfg(rate_cfg),
      .int_o(int_o));
   core_model core (.clk_sys(clk_sys), .ctrl_reset_n(crst_n),
      .cmd_strobe(cmd_strobe), .cmd_byte(cmd_byte), .drive_choose(dsel),
      .ndma_i(ndma), .core_stat(core_stat), .res_push(res_push),
      .res_byte(res_byte));
   // 40 MHz system clock
   always #12.5 clk_sys = ~clk_sys;
   // Count one-cycle port write pulses
   always @(posedge clk_sys) begin
      if (cmd_strobe === 1'b1) begin
         strobes <= strobes + 1;
      end
   end
   task automatic cyc_wait(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Classic cycle: hold the request until ack is sampled high
   task automatic bus(input logic w, input logic [3:0] idx,
         input logic [7:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'h1;
      adr <= {idx, 2'b00};
      wdat <= {24'h0, d};
      do begin
         @(posedge clk_sys);
         n++;
      end while (ack !== 1'b1 && n < 40);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      sel <= 4'h0;
      if (n >= 40) begin
         error_cnt++;
         $display("ERROR at %0t: no bus ack", $time);
      end
   endtask
   task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, idx, 8'h00, q);
      chk(q, exp);
   endtask
   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, idx, d, q);
   endtask
   // Values straight out of reset
   task automatic t_reset;
      chk(crst_n, 0);
      chk(rate_cfg, 0);
      rd(4'h2, 0);
   endtask
   // Unmapped place, read-only status, non-DMA flag
   task automatic t_map;
      rd(4'h3, 0);
      wr(4'h4, 8'hff);
      rd(4'h4, 0);
      ndma <= 1'b1;
      rd(4'h4, 32'h20);
      ndma <= 1'b0;
   endtask
   // Every rate code with its reduce-write flag
   task automatic t_rate;
      for (int i = 0; i < 4; i++) begin
         wr(4'h7, 8'(i));
         cyc_wait(1);
         chk(rate_cfg, {i[1:0], i != 0});
      end
   endtask
   // Motor, select and soft reset bits; soft reset keeps the registers
   task automatic t_control;
      wr(4'h2, 8'hff);
      rd(4'h2, 32'h3d);
      chk({mot2, mot1, dsel, crst_n}, 4'b1111);
      wr(4'h2, 8'h21);
      cyc_wait(1);
      chk({mot2, mot1, dsel, crst_n}, 4'b1010);
      chk(rate_cfg, 3'b111);
      rd(4'h2, 32'h21);
   endtask
   // Change pin, sticky event, mask and interrupt level
   task automatic t_events;
      wr(4'h9, 8'h04);
      pin_n <= 1'b0;
      cyc_wait(3);
      chk(int_o, 1);
      rd(4'h7, 32'h80);
      rd(4'h8, 32'h04);
      chk(int_o, 0);
      rd(4'h8, 0);
      pin_n <= 1'b1;
      wr(4'h9, 8'h00);
      rd(4'h7, 0);
      pin_n <= 1'b0;
      cyc_wait(3);
      chk(int_o, 0);
      rd(4'h8, 32'h04);
      pin_n <= 1'b1;
   endtask
   // Commands on both drives through the data port
   task automatic t_cmd;
      int s0;
      wr(4'h2, 8'h3d);
      rd(4'h4, 32'h80);
      s0 = strobes;
      wr(4'h5, 8'h5a);
      cyc_wait(1);
      chk(strobes - s0, 1);
      chk(cmd_byte, 8'h5a);
      rd(4'h4, 32'h12);
      cyc_wait(25);
      rd(4'h4, 32'hd0);
      chk({disk_irq, dma_req}, 2'b11);
      wr(4'h2, 8'h35);
      cyc_wait(2);
      chk({disk_irq, dma_req}, 2'b00);
      rd(4'h5, 32'h5b);
      rd(4'h5, 0);
      cyc_wait(50);
      rd(4'h4, 32'h80);
      rd(4'h8, 32'h03);
      wr(4'h2, 8'h34);
      wr(4'h5, 8'h01);
      rd(4'h4, 32'h11);
      cyc_wait(25);
      rd(4'h5, 32'h02);
      cyc_wait(50);
   endtask
   // Sixteen results fill the stack; the seventeenth is dropped
   task automatic t_full;
      for (int i = 0; i < 17; i++) begin
         rd(4'h4, 32'h80);
         wr(4'h5, 8'(i));
         cyc_wait(70);
      end
      chk(res_full, 1);
      for (int i = 0; i < 16; i++) begin
         rd(4'h5, i + 1);
         chk(res_full, 0);
      end
      rd(4'h5, 0);
   endtask
   // Interface reset in mid-run clears the output control register
   task automatic t_reset2;
      rst_n <= 1'b0;
      cyc_wait(2);
      rst_n <= 1'b1;
      cyc_wait(1);
      chk({mot2, mot1, crst_n}, 0);
      rd(4'h2, 0);
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      cyc_wait(20);
      rst_n <= 1'b1;
      cyc_wait(1);
      t_reset();
      t_map();
      t_rate();
      t_control();
      t_events();
      t_cmd();
      t_full();
      t_reset2();
      close_out();
   end
   // Whole run needs about sixteen hundred cycles
   initial begin
      cyc_wait(5000);
      error_cnt++;
      close_out();
   end
endmodule
